// >>> design/cbx_exec_core.sv
// Executor for transfer, bit, flag and branch commands issued over APB.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
module cbx_exec_core (
    // Clock and reset.
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_B_IN,
    // APB slave.
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Data memory, read data valid the cycle after the read strobe.
    output logic      [15:0] DM_ADDR_OUT,
    output logic      [7:0]  DM_WDATA_OUT,
    output logic             DM_WE_OUT,
    output logic             DM_RE_OUT,
    input  wire logic [7:0]  DM_RDATA_IN,
    // Code memory, byte addressed.
    output logic      [23:0] PM_ADDR_OUT,
    output logic             PM_RE_OUT,
    input  wire logic [7:0]  PM_RDATA_IN,
    // I/O bit port.
    output logic      [4:0]  IO_ADDR_OUT,
    output logic      [2:0]  IO_BIT_OUT,
    output logic             IO_SET_OUT,
    output logic             IO_CLR_OUT,
    // Core control.
    input  wire logic        DEBUG_EN_IN,
    output logic             SLEEP_REQ_OUT,
    output logic             WDOG_KICK_OUT,
    output logic             DEBUG_BREAK_OUT,
    output logic             BUSY_OUT
);
    import cbx_pkg::*;

    logic        rst_s1_q, rst_n;
    logic [7:0]  gpr_q [32];
    logic [7:0]  flags_q, page_q;
    logic [15:0] pc_q, sp_q;
    cbx_state_e  state_q;
    logic [1:0]  cnt_q, cyc_q, last_clk_q;
    logic [5:0]  op_q;
    logic [4:0]  rd_q, rr_q;
    logic [15:0] imm_q;
    logic        taken_q;
    logic [31:0] prdata_q;

    // Pointer pair selected by the low bits of the second operand field.
    function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
        if (sel == 2'h0) return PTR_X_LO;
        else if (sel == 2'h1) return PTR_Y_LO;
        else return PTR_Z_LO;
    endfunction

    // Number of clocks a command occupies.
    function automatic logic [1:0] op_clocks(input logic [5:0] op, input logic tk);
        if (op >= OP_BVS && op <= OP_BID) return tk ? CLK_TWO : CLK_ONE;
        else if (op >= OP_PM0 && op <= OP_XPMINC) return CLK_THREE;
        else if (op >= OP_RDABS && op <= OP_IOCLR) return CLK_TWO;
        else return CLK_ONE;
    endfunction

    // Reset release through two flip-flops; the second stage is the design reset.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Bus decode; the slave never inserts wait states.
    wire        busy     = (state_q == CBX_EXEC);
    wire        setup    = PSEL_IN && !PENABLE_IN;
    wire        access   = PSEL_IN && PENABLE_IN;
    wire        gpr_hit  = (PADDR_IN[11:7] == OFS_GPR[11:7]) && (PADDR_IN[1:0] == 2'h0);
    wire        reg_hit  = (PADDR_IN == OFS_CMD) || (PADDR_IN == OFS_STATUS) ||
                           (PADDR_IN == OFS_PC) || (PADDR_IN == OFS_FLAGS) ||
                           (PADDR_IN == OFS_SP) || (PADDR_IN == OFS_PAGE) || gpr_hit;
    wire [5:0]  n_op     = PWDATA_IN[CMD_OP_LSB +: 6];
    wire [4:0]  n_rd     = PWDATA_IN[CMD_RD_LSB +: 5];
    wire [4:0]  n_rr     = PWDATA_IN[CMD_RR_LSB +: 5];
    wire [15:0] n_imm    = PWDATA_IN[CMD_IMM_LSB +: 16];
    wire        is_ptrop = (n_op >= OP_RD && n_op <= OP_WROFS);
    wire        is_ofs   = (n_op == OP_RDOFS) || (n_op == OP_WROFS);
    // Offset forms exist for the second and third pointers only.
    wire        cmd_ok   = (n_op <= OP_LAST) && !(is_ptrop && n_rr[1:0] == 2'h3) &&
                           !(is_ofs && n_rr[1:0] == 2'h0);
    wire        bad_wr   = PWRITE_IN && (busy || (PADDR_IN == OFS_STATUS) ||
                           ((PADDR_IN == OFS_CMD) && !cmd_ok));
    wire        bus_err  = !reg_hit || bad_wr;
    wire        apb_wr   = access && PWRITE_IN && !bus_err;
    wire        accept   = apb_wr && (PADDR_IN == OFS_CMD);
    wire        finish   = busy && (cnt_q == 2'h0);
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access && bus_err;
    assign PRDATA_OUT  = prdata_q;
    assign BUSY_OUT    = busy;

    // Address generation for the incoming command.
    wire [4:0]  p_lo     = ptr_lo(n_rr[1:0]);
    wire [4:0]  p_hi     = 5'(p_lo + 5'h1);
    wire [15:0] ptr_cur  = {gpr_q[p_hi], gpr_q[p_lo]};
    wire [15:0] ptr_inc  = 16'(ptr_cur + 16'h1);
    wire [15:0] ptr_dec  = 16'(ptr_cur - 16'h1);
    wire [15:0] z_cur    = {gpr_q[PTR_Z_LO + 5'h1], gpr_q[PTR_Z_LO]};
    wire [23:0] xz_inc   = 24'({page_q, z_cur} + 24'h1);
    wire        pm_ext   = (n_op >= OP_XPM0 && n_op <= OP_XPMINC);
    wire [15:0] dm_addr_n = (n_op == OP_RDABS || n_op == OP_WRABS) ? n_imm :
                            (n_op == OP_RDDEC || n_op == OP_WRDEC) ? ptr_dec :
                            is_ofs ? 16'(ptr_cur + {10'h000, n_imm[5:0]}) :
                            (n_op == OP_PUSH) ? sp_q :
                            (n_op == OP_POP) ? 16'(sp_q + 16'h1) :
                            ptr_cur;
    wire        dm_rd_n  = (n_op == OP_RDABS) || (n_op >= OP_RD && n_op <= OP_RDOFS) ||
                           (n_op == OP_POP);
    wire        dm_wr_n  = (n_op == OP_WRABS) || (n_op >= OP_WR && n_op <= OP_WROFS) ||
                           (n_op == OP_PUSH);
    wire        ptr_upd  = (n_op == OP_RDINC) || (n_op == OP_RDDEC) ||
                           (n_op == OP_WRINC) || (n_op == OP_WRDEC);
    wire [15:0] ptr_new  = (n_op == OP_RDDEC || n_op == OP_WRDEC) ? ptr_dec : ptr_inc;

    // Branch condition on the current flags.
    wire        taken_n  = ((n_op == OP_BVS) && flags_q[FL_V]) ||
                           ((n_op == OP_BVC) && !flags_q[FL_V]) ||
                           ((n_op == OP_BIE) && flags_q[FL_I]) ||
                           ((n_op == OP_BID) && !flags_q[FL_I]);

    // Result of the finishing command; loads take the memory byte in their last cycle.
    wire [7:0]  src_b    = gpr_q[rr_q];
    wire [7:0]  dst_b    = gpr_q[rd_q];
    wire [2:0]  bsel     = imm_q[2:0];
    wire [7:0]  rot_l    = {dst_b[6:0], flags_q[FL_C]};
    wire [7:0]  rot_r    = {flags_q[FL_C], dst_b[7:1]};
    wire        rot_c    = (op_q == OP_ROTL) ? dst_b[7] : dst_b[0];
    wire [7:0]  rot_res  = (op_q == OP_ROTL) ? rot_l : rot_r;
    wire        is_pm    = (op_q >= OP_PM0 && op_q <= OP_XPMINC);
    wire        is_dmrd  = (op_q == OP_RDABS) || (op_q >= OP_RD && op_q <= OP_RDOFS) ||
                           (op_q == OP_POP);
    wire        wb_en    = is_pm || is_dmrd || (op_q == OP_COPY) || (op_q == OP_IMM) ||
                           (op_q == OP_ROTL) || (op_q == OP_ROTR) || (op_q == OP_TLOAD);
    wire [4:0]  wb_idx   = (op_q == OP_PM0 || op_q == OP_XPM0) ? 5'h00 : rd_q;
    wire [7:0]  bld_res  = (dst_b & ~(8'h01 << bsel)) | ({7'h00, flags_q[FL_T]} << bsel);
    wire [7:0]  wb_data  = is_pm ? PM_RDATA_IN :
                           is_dmrd ? DM_RDATA_IN :
                           (op_q == OP_COPY) ? src_b :
                           (op_q == OP_IMM) ? imm_q[7:0] :
                           (op_q == OP_TLOAD) ? bld_res :
                           rot_res;
    wire [15:0] pc_next  = taken_q ? 16'(pc_q + {{9{imm_q[6]}}, imm_q[6:0]} + 16'h1) :
                           (op_q == OP_RDABS || op_q == OP_WRABS) ? 16'(pc_q + 16'h2) :
                           16'(pc_q + 16'h1);

    // Flag update; only rotates, the transfer bit store and flag set or clear touch flags.
    logic [7:0] flags_x;
    always_comb begin
        flags_x = flags_q;
        if (op_q == OP_ROTL || op_q == OP_ROTR) begin
            flags_x[FL_C] = rot_c;
            flags_x[FL_Z] = (rot_res == 8'h00);
            flags_x[FL_N] = rot_res[7];
            flags_x[FL_V] = rot_res[7] ^ rot_c;
        end else if (op_q == OP_TSTORE) begin
            flags_x[FL_T] = src_b[bsel];
        end else if (op_q == OP_FSET || op_q == OP_FCLR) begin
            flags_x[bsel] = (op_q == OP_FSET);
        end
    end

    // Read mux, captured in the setup phase so the data stands through the access phase.
    wire [31:0] rd_mux = (PADDR_IN == OFS_CMD) ?
                             {imm_q, rr_q, rd_q, op_q} :
                         (PADDR_IN == OFS_STATUS) ? {26'h0, last_clk_q, 3'h0, busy} :
                         (PADDR_IN == OFS_PC) ? {16'h0, pc_q} :
                         (PADDR_IN == OFS_FLAGS) ? {24'h0, flags_q} :
                         (PADDR_IN == OFS_SP) ? {16'h0, sp_q} :
                         (PADDR_IN == OFS_PAGE) ? {24'h0, page_q} :
                         gpr_hit ? {24'h0, gpr_q[PADDR_IN[6:2]]} : 32'h0;
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) prdata_q <= 32'h0;
        else if (setup) prdata_q <= rd_mux;
    end

    // Sequencer: a command holds the executor for exactly its clock count.
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CBX_IDLE;
            cnt_q <= 2'h0;
            cyc_q <= 2'h0;
            last_clk_q <= 2'h0;
        end else if (accept) begin
            state_q <= CBX_EXEC;
            cnt_q <= 2'(op_clocks(n_op, taken_n) - 2'h1);
            cyc_q <= CLK_ONE;
        end else if (finish) begin
            state_q <= CBX_IDLE;
            last_clk_q <= cyc_q;
        end else if (busy) begin
            cnt_q <= 2'(cnt_q - 2'h1);
            cyc_q <= 2'(cyc_q + 2'h1);
        end
    end

    // Command latch.
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= OP_NOP;
            rd_q <= 5'h00;
            rr_q <= 5'h00;
            imm_q <= 16'h0000;
            taken_q <= 1'b0;
        end else if (accept) begin
            op_q <= n_op;
            rd_q <= n_rd;
            rr_q <= n_rr;
            imm_q <= n_imm;
            taken_q <= taken_n;
        end
    end

    // Working registers: pointer steps land at issue, results land in the last cycle.
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) gpr_q[i] <= 8'h00;
        end else begin
            if (apb_wr && gpr_hit) gpr_q[PADDR_IN[6:2]] <= PWDATA_IN[7:0];
            if (accept && ptr_upd) begin
                gpr_q[p_lo] <= ptr_new[7:0];
                gpr_q[p_hi] <= ptr_new[15:8];
            end
            if (accept && (n_op == OP_PMINC || n_op == OP_XPMINC)) begin
                gpr_q[PTR_Z_LO] <= xz_inc[7:0];
                gpr_q[PTR_Z_LO + 5'h1] <= xz_inc[15:8];
            end
            if (finish && wb_en) gpr_q[wb_idx] <= wb_data;
            if (finish && op_q == OP_PCOPY) begin
                gpr_q[{rd_q[4:1], 1'b0}] <= gpr_q[{rr_q[4:1], 1'b0}];
                gpr_q[{rd_q[4:1], 1'b1}] <= gpr_q[{rr_q[4:1], 1'b1}];
            end
        end
    end

    // Flags, program counter, stack pointer and code page.
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RST;
            pc_q <= PC_RST;
            sp_q <= SP_RST;
            page_q <= PAGE_RST;
        end else begin
            if (apb_wr && PADDR_IN == OFS_FLAGS) flags_q <= PWDATA_IN[7:0];
            else if (finish) flags_q <= flags_x;
            if (apb_wr && PADDR_IN == OFS_PC) pc_q <= PWDATA_IN[15:0];
            else if (finish) pc_q <= pc_next;
            if (apb_wr && PADDR_IN == OFS_SP) sp_q <= PWDATA_IN[15:0];
            else if (accept && n_op == OP_PUSH) sp_q <= 16'(sp_q - 16'h1);
            else if (accept && n_op == OP_POP) sp_q <= 16'(sp_q + 16'h1);
            if (apb_wr && PADDR_IN == OFS_PAGE) page_q <= PWDATA_IN[7:0];
            else if (accept && n_op == OP_XPMINC) page_q <= xz_inc[23:16];
        end
    end

    // Memory and side-band strobes are registered and last one cycle after issue.
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            DM_ADDR_OUT <= 16'h0000;
            DM_WDATA_OUT <= 8'h00;
            DM_WE_OUT <= 1'b0;
            DM_RE_OUT <= 1'b0;
            PM_ADDR_OUT <= 24'h000000;
            PM_RE_OUT <= 1'b0;
            IO_ADDR_OUT <= 5'h00;
            IO_BIT_OUT <= 3'h0;
            IO_SET_OUT <= 1'b0;
            IO_CLR_OUT <= 1'b0;
            SLEEP_REQ_OUT <= 1'b0;
            WDOG_KICK_OUT <= 1'b0;
            DEBUG_BREAK_OUT <= 1'b0;
        end else begin
            DM_WE_OUT <= accept && dm_wr_n;
            DM_RE_OUT <= accept && dm_rd_n;
            PM_RE_OUT <= accept && (n_op >= OP_PM0 && n_op <= OP_XPMINC);
            IO_SET_OUT <= accept && (n_op == OP_IOSET);
            IO_CLR_OUT <= accept && (n_op == OP_IOCLR);
            SLEEP_REQ_OUT <= accept && (n_op == OP_SLEEP);
            WDOG_KICK_OUT <= accept && (n_op == OP_WDOG);
            // Without the debugger the break is a plain one-clock no-operation.
            DEBUG_BREAK_OUT <= accept && (n_op == OP_BREAK) && DEBUG_EN_IN;
            if (accept) begin
                DM_ADDR_OUT <= dm_addr_n;
                DM_WDATA_OUT <= gpr_q[n_rd];
                PM_ADDR_OUT <= pm_ext ? {page_q, z_cur} : {8'h00, z_cur};
                IO_ADDR_OUT <= n_imm[12:8];
                IO_BIT_OUT <= n_imm[2:0];
            end
        end
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!rst_n);

    a_branch_taken_len: assert property (accept && n_op >= OP_BVS && n_op <= OP_BID && taken_n
        |=> busy ##1 busy ##1 !busy ##0 pc_q == 16'($past(pc_q, 3) +
        {{9{$past(imm_q[6], 2)}}, $past(imm_q[6:0], 2)} + 16'h1))
        else $error("taken branch length or target wrong");
    a_branch_skip_len: assert property (accept && (n_op == OP_BIE || n_op == OP_BID) &&
        !taken_n |=> busy ##1 !busy ##0 pc_q == 16'($past(pc_q, 2) + 16'h1))
        else $error("untaken branch wrong");
    a_abs_read_addr: assert property (accept && n_op == OP_RDABS |=> DM_RE_OUT &&
        DM_ADDR_OUT == $past(n_imm) ##1 !DM_RE_OUT ##1 gpr_q[rd_q] == $past(DM_RDATA_IN)
        && flags_q == $past(flags_q, 2))
        else $error("absolute read wrong");
    a_post_inc_ptr: assert property (accept && (n_op == OP_RDINC || n_op == OP_WRINC)
        |=> DM_ADDR_OUT == $past(ptr_cur) && {gpr_q[$past(p_hi)], gpr_q[$past(p_lo)]} ==
        16'($past(ptr_cur) + 16'h1))
        else $error("post-increment pointer wrong");
    a_pre_dec_ptr: assert property (accept && (n_op == OP_RDDEC || n_op == OP_WRDEC)
        |=> DM_ADDR_OUT == 16'($past(ptr_cur) - 16'h1))
        else $error("pre-decrement address wrong");
    a_code_read_len: assert property (accept && n_op >= OP_PM0 && n_op <= OP_XPMINC
        |=> busy[*3] ##1 !busy ##0 last_clk_q == CLK_THREE)
        else $error("code read length wrong");
    a_push_write: assert property (accept && n_op == OP_PUSH |=> DM_WE_OUT &&
        DM_ADDR_OUT == $past(sp_q) && DM_WDATA_OUT == $past(gpr_q[n_rd]) &&
        sp_q == 16'($past(sp_q) - 16'h1))
        else $error("push wrong");
    a_io_set_pulse: assert property (accept && n_op == OP_IOSET |=> IO_SET_OUT &&
        !IO_CLR_OUT && busy ##1 !IO_SET_OUT && busy ##1 !busy)
        else $error("io bit set wrong");
    a_flag_set_only: assert property (finish && op_q == OP_FSET |=>
        flags_q == ($past(flags_q) | (8'h01 << $past(imm_q[2:0]))))
        else $error("flag set touched other flags");
    a_sleep_one_clk: assert property (accept && n_op == OP_SLEEP |=> SLEEP_REQ_OUT
        && busy ##1 !busy)
        else $error("sleep issue wrong");
endmodule

// >>> include/cbx_pkg.sv
// Constants, command encoding and register map of the transfer, bit and branch executor.
// Contract
// - Overflow-flag branches go to PC+k+1 when the test holds; one clock, two when taken.
// - Interrupt-enable branches go to PC+k+1 when the test holds; one or two clocks.
// - Absolute read copies data byte at address k into the register in two clocks.
// - Absolute write stores the register at address k in two clocks, flags untouched.
// - Post-increment pointer read uses the old pointer, then adds one; two clocks.
// - Pre-decrement pointer read subtracts one first, then reads there; two clocks.
// - Offset read through second or third pointer reads pointer plus q; two clocks.
// - Post-increment pointer write stores at the old pointer, then adds one; two clocks.
// - Pre-decrement pointer write subtracts one first, then stores there; two clocks.
// - Offset write through second or third pointer stores at pointer plus q; two clocks.
// - Code memory read fetches byte at third pointer into r0 or a register; three clocks.
// - Extended code read prefixes the page byte; increment covers the whole address.
// - Push places the register on the stack in two clocks, flags untouched.
// - Pop returns the top stack byte into the register in two clocks, flags untouched.
// - I/O bit set and clear force bit b of location P; two clocks, flags kept.
// - Rotate left through carry updates Z, C, N and V in one clock.
// - Rotate right through carry updates Z, C, N and V in one clock.
// - Bit store copies register bit b into the transfer flag only, one clock.
// - Bit load writes the transfer flag into register bit b, one clock.
// - Each flag has its own set and clear, touching only that flag, one clock.
// - Sleep, watchdog kick and no-operation take one clock; the first two signal out.
// - Break acts only for the on-chip debug system; no cycle count defined.
package cbx_pkg;
    // Register map, byte addresses on the APB.
    localparam logic [11:0] OFS_CMD    = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_PC     = 12'h008;
    localparam logic [11:0] OFS_FLAGS  = 12'h00C;
    localparam logic [11:0] OFS_SP     = 12'h010;
    localparam logic [11:0] OFS_PAGE   = 12'h014;
    localparam logic [11:0] OFS_GPR    = 12'h080;
    // Command word fields.
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_RD_LSB  = 6;
    localparam int CMD_RR_LSB  = 11;
    localparam int CMD_IMM_LSB = 16;
    // Bit positions inside the flag register.
    localparam int FL_C = 0;
    localparam int FL_Z = 1;
    localparam int FL_N = 2;
    localparam int FL_V = 3;
    localparam int FL_S = 4;
    localparam int FL_H = 5;
    localparam int FL_T = 6;
    localparam int FL_I = 7;
    // Pointer pair low-byte register indices.
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    // Reset values.
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [15:0] SP_RST    = 16'h00FF;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [7:0]  PAGE_RST  = 8'h00;
    // Command codes.
    localparam logic [5:0] OP_NOP = 6'h00, OP_SLEEP = 6'h01, OP_WDOG = 6'h02, OP_BREAK = 6'h03;
    localparam logic [5:0] OP_BVS = 6'h04, OP_BVC = 6'h05, OP_BIE = 6'h06, OP_BID = 6'h07;
    localparam logic [5:0] OP_COPY = 6'h08, OP_PCOPY = 6'h09, OP_IMM = 6'h0A;
    localparam logic [5:0] OP_RDABS = 6'h0B, OP_WRABS = 6'h0C;
    localparam logic [5:0] OP_RD = 6'h0D, OP_RDINC = 6'h0E, OP_RDDEC = 6'h0F, OP_RDOFS = 6'h10;
    localparam logic [5:0] OP_WR = 6'h11, OP_WRINC = 6'h12, OP_WRDEC = 6'h13, OP_WROFS = 6'h14;
    localparam logic [5:0] OP_PM0 = 6'h15, OP_PM = 6'h16, OP_PMINC = 6'h17;
    localparam logic [5:0] OP_XPM0 = 6'h18, OP_XPM = 6'h19, OP_XPMINC = 6'h1A;
    localparam logic [5:0] OP_PUSH = 6'h1B, OP_POP = 6'h1C, OP_IOSET = 6'h1D, OP_IOCLR = 6'h1E;
    localparam logic [5:0] OP_ROTL = 6'h1F, OP_ROTR = 6'h20, OP_TSTORE = 6'h21;
    localparam logic [5:0] OP_TLOAD = 6'h22, OP_FSET = 6'h23, OP_FCLR = 6'h24;
    localparam logic [5:0] OP_LAST = 6'h24;
    // Execution lengths in clocks.
    localparam logic [1:0] CLK_ONE = 2'h1, CLK_TWO = 2'h2, CLK_THREE = 2'h3;
    typedef enum logic {CBX_IDLE, CBX_EXEC} cbx_state_e;
endpackage

// >>> dv/cbx_mem_model.sv
// Behavioural data and code memory standing at the far side of the executor.
`timescale 1ns/1ns
module cbx_mem_model (
    // Clock.
    input  wire logic        clk_in,
    // Data and code memory requests.
    input  wire logic [15:0] dm_addr_in,
    input  wire logic [7:0]  dm_wdata_in,
    input  wire logic        dm_we_in,
    input  wire logic        dm_re_in,
    input  wire logic [23:0] pm_addr_in,
    input  wire logic        pm_re_in,
    // Read data, turned over once its hold time has run out.
    output logic      [7:0]  dm_rdata_out,
    output logic      [7:0]  pm_rdata_out
);
    logic [7:0] mem [0:255];
    logic [1:0] pm_age;
    // Known contents let the bench predict every read.
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        dm_rdata_out = 8'h00;
        pm_rdata_out = 8'h00;
        pm_age = 2'h0;
    end
    // Stale data is inverted so a late sample by the design cannot pass by luck.
    always @(posedge clk_in) begin
        if (dm_we_in) mem[dm_addr_in[7:0]] <= dm_wdata_in;
        dm_rdata_out <= dm_re_in ? mem[dm_addr_in[7:0]] : ~dm_rdata_out;
        pm_age <= pm_re_in ? 2'h0 : pm_age + 2'h1;
        if (pm_re_in) pm_rdata_out <= pm_addr_in[7:0] ^ pm_addr_in[23:16] ^ 8'hC3;
        else if (pm_age == 2'h1) pm_rdata_out <= ~pm_rdata_out;
    end
endmodule

// >>> dv/cpu_transfer_bit_branch_exec_test.sv
// Self-checking bench for the transfer, bit and branch executor.
`timescale 1ns/1ns
module cpu_transfer_bit_branch_exec_test;
    import cbx_pkg::*;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, dm_we, dm_re, pm_re;
    logic pready, pslverr, e, io_set, slp;
    logic [4:0] io_addr;
    logic [2:0] io_bit;
    logic [7:0] io_seen = 8'h00;
    int n_sleep = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, pc0;
    logic [15:0] dm_addr;
    logic [7:0] dm_wdata, dm_rdata, pm_rdata;
    logic [23:0] pm_addr;
    int n_errors = 0, checks_done = 0;
    always #20 clk = ~clk;
    cbx_exec_core cbx_exec_core_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DM_ADDR_OUT(dm_addr),
        .DM_WDATA_OUT(dm_wdata), .DM_WE_OUT(dm_we), .DM_RE_OUT(dm_re), .DM_RDATA_IN(dm_rdata),
        .PM_ADDR_OUT(pm_addr), .PM_RE_OUT(pm_re), .PM_RDATA_IN(pm_rdata), .IO_ADDR_OUT(io_addr),
        .IO_BIT_OUT(io_bit), .IO_SET_OUT(io_set), .IO_CLR_OUT(), .DEBUG_EN_IN(1'b1),
        .SLEEP_REQ_OUT(slp), .WDOG_KICK_OUT(), .DEBUG_BREAK_OUT(), .BUSY_OUT());
    // Side-band pulses last one cycle, so they are caught here as they pass.
    always @(posedge clk) if (io_set) io_seen <= {io_addr, io_bit};
    always @(posedge clk) if (slp) n_sleep <= n_sleep + 1;
    cbx_mem_model cbx_mem_model_i (.clk_in(clk), .dm_addr_in(dm_addr), .dm_wdata_in(dm_wdata),
        .dm_we_in(dm_we), .dm_re_in(dm_re), .pm_addr_in(pm_addr), .pm_re_in(pm_re),
        .dm_rdata_out(dm_rdata), .pm_rdata_out(pm_rdata));
    // One APB transfer; the leading edge keeps two transfers from touching in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Issue a command, poll until idle, then judge the reported clock count.
    task automatic run(input logic [5:0] op, input int rd, rr, input logic [15:0] imm, input int n);
        apb(1, OFS_CMD, {imm, 5'(rr), 5'(rd), op});
        do apb(0, OFS_STATUS, 0); while (r[0] !== 1'b0);
        chk("clocks", 32'(n), {30'h0, r[5:4]});
    endtask
    task automatic reg_is(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e, r);
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1, OFS_GPR + 12'h014, 32'h3C);
        run(OP_WRABS, 5, 0, 16'h0040, 2);
        run(OP_RDABS, 6, 0, 16'h0040, 2);
        reg_is("r6", OFS_GPR + 12'h018, 32'h3C);
        apb(1, OFS_GPR + 12'h068, 32'h10);
        run(OP_RDINC, 7, 0, 0, 2);
        reg_is("r7", OFS_GPR + 12'h01C, 32'h4A);
        reg_is("xlo", OFS_GPR + 12'h068, 32'h11);
        apb(1, OFS_GPR + 12'h070, 32'h20);
        run(OP_WRDEC, 5, 1, 0, 2);
        chk("dm_addr", 32'h1F, 32'(dm_addr));
        apb(1, OFS_PAGE, 32'h01);
        apb(1, OFS_GPR + 12'h078, 32'hFF);
        apb(1, OFS_GPR + 12'h07C, 32'hFF);
        run(OP_XPMINC, 8, 0, 0, 3);
        reg_is("r8", OFS_GPR + 12'h020, 32'h3D);
        reg_is("page", OFS_PAGE, 32'h02);
        reg_is("zhi", OFS_GPR + 12'h07C, 32'h00);
        apb(1, OFS_FLAGS, 32'h00);
        run(OP_BVS, 0, 0, 16'h0005, 1);
        run(OP_FSET, 0, 0, 16'h0003, 1);
        reg_is("flags", OFS_FLAGS, 32'h08);
        reg_is("pc", OFS_PC, 32'h9);
        pc0 = r;
        run(OP_BVS, 0, 0, 16'h0005, 2);
        reg_is("pc", OFS_PC, pc0 + 32'h6);
        apb(1, OFS_FLAGS, 32'h00);
        apb(1, OFS_GPR + 12'h024, 32'h80);
        run(OP_ROTL, 9, 0, 0, 1);
        reg_is("r9", OFS_GPR + 12'h024, 32'h00);
        reg_is("flags", OFS_FLAGS, 32'h0B);
        run(OP_BIE, 0, 0, 16'h0004, 1);
        run(OP_IOSET, 0, 0, 16'h0A05, 2);
        chk("io", 32'h55, 32'(io_seen));
        run(OP_SLEEP, 0, 0, 0, 1);
        chk("sleep", 32'h1, 32'(n_sleep));
        apb(1, OFS_CMD, {16'h0001, 5'h00, 5'h03, OP_RDOFS});
        chk("pslverr", 32'h1, {31'h0, e});
        reg_is("status", OFS_STATUS, 32'h10);
        end_of_test;
    end
endmodule
